// *** sorb_pkg.sv ***
// Constants, field layouts and carriers for the supported-opcode report builder.
// Assumes a single clock domain and a command table held by the surrounding logic.
package sorb_pkg;
    // Parameter data layout
    localparam logic [7:0] HDR_LEN = 8'h04;
    localparam logic [7:0] DESC_LEN = 8'h08;
    localparam logic [7:0] TO_LEN = 8'h0C;
    localparam logic [7:0] TO_DLEN = 8'h0A;
    localparam logic [7:0] ONE_HDR = 8'h04;
    localparam logic [7:0] FLAG_POS = 8'h05;
    localparam logic [7:0] CDBL_POS = 8'h07;
    localparam logic [7:0] SA_MASK = 8'h1F;
    // Reporting options
    localparam logic [2:0] OPT_ALL = 3'h0;
    localparam logic [2:0] OPT_OP = 3'h1;
    localparam logic [2:0] OPT_OPSA = 3'h2;
    localparam logic [2:0] OPT_CHK = 3'h3;
    // Output buffer shape and sent-byte count reset value
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 8;
    localparam logic [31:0] SENT_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        SUP_NA = 3'b000,
        SUP_NO = 3'b001,
        SUP_STD = 3'b011,
        SUP_VEN = 3'b101
    } sorb_sup_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_SCAN = 3'b001,
        S_HDR = 3'b010,
        S_DESC = 3'b011,
        S_ONE = 3'b100,
        S_DONE = 3'b101
    } sorb_st_e;

    typedef struct packed {
        logic [2:0] opt;
        logic return_timeout_desc_request;
        logic [7:0] op;
        logic [15:0] sa;
        logic [31:0] alloc;
    } sorb_req_s;

    typedef struct packed {
        logic [7:0] op;
        logic [15:0] sa;
        logic sa_valid;
        logic vendor;
        logic cs_valid;
        logic [7:0] cs;
        logic [4:0] cdb_len;
        logic [3:0] sa_pos;
        logic [0:15][7:0] usage;
        logic [31:0] nom;
        logic [31:0] rec;
    } sorb_ent_s;
endpackage

// *** sorb_report.sv ***
// Supported-opcode report builder: turns a request into a byte stream.
// Assumes the table entry at tbl_idx_o is presented on tbl_ent_i in the
// same cycle, and that all inputs come from logic on clk_sys_i.
`timescale 1ns/1ns

module sorb_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    // Full and empty straight from the occupancy count
    assign in_ready_o = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    // Storage has no reset; only pointers matter
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    // Pointers wrap at the depth
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module sorb_report (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire sorb_pkg::sorb_req_s req_i,
    output logic busy_o,
    output logic done_o,
    output logic opt_err_o,
    input wire logic tbl_ready_i,
    input wire logic [7:0] tbl_count_i,
    output logic [7:0] tbl_idx_o,
    input wire sorb_pkg::sorb_ent_s tbl_ent_i,
    output logic m_valid_o,
    input wire logic m_ready_i,
    output logic [7:0] m_data_o
);
    sorb_pkg::sorb_st_e st_q, st_d;
    sorb_pkg::sorb_sup_e sup_q, sup_d;
    sorb_pkg::sorb_req_s req_q;
    logic [7:0] b_q, b_d, idx_q, idx_d, dlen, olen, cdb, ub, gbyte;
    logic [31:0] sent_q, hlen;
    logic err_q, sup_ok, hit, emit, f_ready, push, last, stop, in_to;
    logic [3:0] to_k, uk;
    // Timeout descriptor byte k, big-endian words
    function automatic logic [7:0] to_byte(input logic [3:0] k,
                                           input sorb_pkg::sorb_ent_s e);
        logic [7:0] r;
        case (k)
            4'h1: r = sorb_pkg::TO_DLEN;
            4'h3: r = e.cs_valid ? e.cs : 8'h00;
            4'h4, 4'h5, 4'h6, 4'h7: r = 8'(e.nom >> {2'h3 - k[1:0], 3'h0});
            4'h8, 4'h9, 4'hA, 4'hB: r = 8'(e.rec >> {2'h3 - k[1:0], 3'h0});
            default: r = 8'h00;
        endcase
        return r;
    endfunction
    // Lengths; the header counts full data even when truncated
    assign cdb = {3'h0, tbl_ent_i.cdb_len};
    assign dlen = sorb_pkg::DESC_LEN + (req_q.return_timeout_desc_request ? sorb_pkg::TO_LEN : 8'h00);
    assign hlen = 32'(tbl_count_i) * 32'(dlen);
    assign sup_ok = (sup_q == sorb_pkg::SUP_STD) || (sup_q == sorb_pkg::SUP_VEN);
    assign olen = sup_ok ?
        sorb_pkg::ONE_HDR + cdb + (req_q.return_timeout_desc_request ? sorb_pkg::TO_LEN : 8'h00) :
        sorb_pkg::ONE_HDR;
    assign hit = (tbl_ent_i.op == req_q.op) && (tbl_ent_i.sa_valid ?
        (req_q.opt != sorb_pkg::OPT_OP && tbl_ent_i.sa == req_q.sa) :
        (req_q.opt != sorb_pkg::OPT_OPSA &&
         (req_q.opt != sorb_pkg::OPT_CHK || req_q.sa == 16'h0000)));
    // Byte stream stalls on a full buffer
    assign emit = (st_q == sorb_pkg::S_HDR) || (st_q == sorb_pkg::S_DESC) ||
                  (st_q == sorb_pkg::S_ONE);
    assign push = emit && f_ready;
    assign last = (b_q == ((st_q == sorb_pkg::S_HDR) ? sorb_pkg::HDR_LEN - 8'h01 :
                           (st_q == sorb_pkg::S_DESC) ? dlen - 8'h01 : olen - 8'h01));
    assign stop = (sent_q == req_q.alloc - 32'h0000_0001);
    // Usage map byte with opcode and service action laid in
    always_comb begin
        uk = 4'(b_q - sorb_pkg::ONE_HDR);
        ub = tbl_ent_i.usage[uk];
        // opcode first, SA in its slot
        if (uk == 4'h0) begin
            ub = tbl_ent_i.op;
        end else if (tbl_ent_i.sa_valid && uk == tbl_ent_i.sa_pos) begin
            ub = (ub & ~sorb_pkg::SA_MASK) | (tbl_ent_i.sa[7:0] & sorb_pkg::SA_MASK);
        end
    end
    // Byte generator per state and byte index
    always_comb begin
        in_to = 1'b0;
        to_k = 4'h0;
        gbyte = 8'h00;
        case (st_q)
            sorb_pkg::S_HDR: gbyte = 8'(hlen >> {2'h3 - b_q[1:0], 3'h0});
            sorb_pkg::S_DESC: begin
                case (b_q)
                    8'h00: gbyte = tbl_ent_i.op;
                    8'h02: gbyte = tbl_ent_i.sa_valid ? tbl_ent_i.sa[15:8] : 8'h00;
                    8'h03: gbyte = tbl_ent_i.sa_valid ? tbl_ent_i.sa[7:0] : 8'h00;
                    sorb_pkg::FLAG_POS: gbyte = {6'h00, req_q.return_timeout_desc_request, tbl_ent_i.sa_valid};
                    sorb_pkg::CDBL_POS: gbyte = cdb;
                    8'h01, 8'h04, 8'h06: gbyte = 8'h00;
                    default: begin
                        in_to = 1'b1;
                        to_k = 4'(b_q - sorb_pkg::DESC_LEN);
                    end
                endcase
            end
            sorb_pkg::S_ONE: begin
                if (b_q == 8'h01) begin
                    gbyte = {req_q.return_timeout_desc_request && sup_ok, 4'h0, sup_q};
                end else if (b_q == 8'h03) begin
                    gbyte = sup_ok ? cdb : 8'h00;
                end else if (b_q < sorb_pkg::ONE_HDR) begin
                    gbyte = 8'h00;
                end else if (b_q < sorb_pkg::ONE_HDR + cdb) begin
                    gbyte = ub;
                end else begin
                    in_to = 1'b1;
                    to_k = 4'(b_q - sorb_pkg::ONE_HDR - cdb);
                end
            end
            default: gbyte = 8'h00;
        endcase
        if (in_to) begin
            gbyte = to_byte(to_k, tbl_ent_i);
        end
    end

    // Sequencer
    always_comb begin
        st_d = st_q;
        b_d = b_q;
        idx_d = idx_q;
        sup_d = sup_q;
        case (st_q)
            sorb_pkg::S_IDLE: begin
                if (req_valid_i) begin
                    b_d = 8'h00;
                    idx_d = 8'h00;
                    if (req_i.alloc == 32'h0000_0000 || req_i.opt > sorb_pkg::OPT_CHK) begin
                        st_d = sorb_pkg::S_DONE;
                    end else if (req_i.opt == sorb_pkg::OPT_ALL) begin
                        st_d = sorb_pkg::S_HDR;
                    end else if (!tbl_ready_i) begin
                        sup_d = sorb_pkg::SUP_NA;
                        st_d = sorb_pkg::S_ONE;
                    end else if (tbl_count_i == 8'h00) begin
                        sup_d = sorb_pkg::SUP_NO;
                        st_d = sorb_pkg::S_ONE;
                    end else begin
                        st_d = sorb_pkg::S_SCAN;
                    end
                end
            end
            sorb_pkg::S_SCAN: begin
                if (hit) begin
                    sup_d = tbl_ent_i.vendor ? sorb_pkg::SUP_VEN : sorb_pkg::SUP_STD;
                    st_d = sorb_pkg::S_ONE;
                end else if (idx_q == tbl_count_i - 8'h01) begin
                    sup_d = sorb_pkg::SUP_NO;
                    st_d = sorb_pkg::S_ONE;
                end else begin
                    idx_d = idx_q + 8'h01;
                end
            end
            sorb_pkg::S_HDR, sorb_pkg::S_DESC, sorb_pkg::S_ONE: begin
                if (push) begin
                    b_d = b_q + 8'h01;
                    if (stop) begin
                        st_d = sorb_pkg::S_DONE;
                    end else if (last) begin
                        b_d = 8'h00;
                        if (st_q == sorb_pkg::S_ONE) begin
                            st_d = sorb_pkg::S_DONE;
                        end else if (st_q == sorb_pkg::S_HDR) begin
                            st_d = (tbl_count_i == 8'h00) ? sorb_pkg::S_DONE : sorb_pkg::S_DESC;
                        end else if (idx_q == tbl_count_i - 8'h01) begin
                            st_d = sorb_pkg::S_DONE;
                        end else begin
                            idx_d = idx_q + 8'h01;
                        end
                    end
                end
            end
            sorb_pkg::S_DONE: st_d = sorb_pkg::S_IDLE;
            default: st_d = sorb_pkg::S_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= sorb_pkg::S_IDLE;
            b_q <= 8'h00;
            idx_q <= 8'h00;
            sup_q <= sorb_pkg::SUP_NA;
        end else begin
            st_q <= st_d;
            b_q <= b_d;
            idx_q <= idx_d;
            sup_q <= sup_d;
        end
    end

    // Request capture, byte count and option error
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_q <= '0;
            sent_q <= sorb_pkg::SENT_RST;
            err_q <= 1'b0;
        end else if (st_q == sorb_pkg::S_IDLE && req_valid_i) begin
            req_q <= req_i;
            sent_q <= sorb_pkg::SENT_RST;
            err_q <= (req_i.opt > sorb_pkg::OPT_CHK);
        end else if (push) begin
            sent_q <= sent_q + 32'h0000_0001;
        end
    end

    assign busy_o = (st_q != sorb_pkg::S_IDLE);
    assign done_o = (st_q == sorb_pkg::S_DONE);
    assign opt_err_o = err_q;
    assign tbl_idx_o = idx_q;
    // Buffer lets the host drain at its own pace
    sorb_fifo #(
        .W(sorb_pkg::FIFO_W),
        .D(sorb_pkg::FIFO_D)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .in_valid_i(emit),
        .in_ready_o(f_ready),
        .in_data_i(gbyte),
        .out_valid_o(m_valid_o),
        .out_ready_i(m_ready_i),
        .out_data_o(m_data_o)
    );

    // Checks on the generated stream
    a_hdr_msb: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_HDR && b_q == 8'h00 |-> gbyte == hlen[31:24])
        else $error("length header not MSB first");
    a_desc_sa0: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_DESC && b_q == 8'h03 && !tbl_ent_i.sa_valid
        |-> gbyte == 8'h00)
        else $error("service action not zero");
    a_desc_flags: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_DESC && b_q == sorb_pkg::FLAG_POS
        |-> gbyte[1:0] == {req_q.return_timeout_desc_request, tbl_ent_i.sa_valid} && dlen[4] == req_q.return_timeout_desc_request)
        else $error("descriptor flags wrong");
    a_desc_cdb: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_DESC && b_q == sorb_pkg::CDBL_POS
        |-> gbyte[4:0] == tbl_ent_i.cdb_len)
        else $error("cdb length wrong");
    a_one_short: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_ONE && b_q == 8'h01 && !sup_ok
        |-> gbyte[7] == 1'b0 && olen == sorb_pkg::ONE_HDR
        ##1 (st_q == sorb_pkg::S_ONE || st_q == sorb_pkg::S_DONE))
        else $error("invalid support sent extra");
    a_one_op: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && st_q == sorb_pkg::S_ONE && sup_ok && b_q == sorb_pkg::ONE_HDR
        |-> gbyte == tbl_ent_i.op)
        else $error("usage byte 0 not opcode");
    a_to_len: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && in_to && to_k == 4'h1 |-> gbyte == 8'h0A && req_q.return_timeout_desc_request)
        else $error("timeout length wrong");
    a_alloc_cap: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        push && stop |=> st_q == sorb_pkg::S_DONE ##1 st_q == sorb_pkg::S_IDLE)
        else $error("stream ran past allocation");
endmodule

// *** sorb_sink.sv ***
// Byte sink standing in for the initiator that reads the report stream.
// Assumes one clock domain; the bench reads and clears the captured queue.
`timescale 1ns/1ns

module sorb_sink (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic hold_i,
    input wire logic slow_i,
    output logic ready_o
);
    logic [1:0] pace_q;
    logic [7:0] got[$];

    // Pace counter; slow mode takes one byte in four to stress the buffer
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pace_q <= 2'h0;
            ready_o <= 1'b0;
        end else begin
            pace_q <= pace_q + 2'h1;
            ready_o <= !hold_i && (!slow_i || pace_q == 2'h3);
        end
    end

    // Capture on handshake; the bench checks the count and every captured byte
    always @(posedge clk_sys_i) begin
        if (resetn_i && valid_i && ready_o) begin
            got.push_back(data_i);
        end
    end
endmodule

// *** testbench.sv ***
// Self-checking bench for the supported-opcode report builder.
// Assumes sorb_pkg, sorb_report and sorb_sink are compiled before this file.
`timescale 1ns/1ns

module testbench;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_valid = 1'b0;
    sorb_pkg::sorb_req_s req = '0;
    logic tbl_ready = 1'b1;
    logic [7:0] tbl_count = 8'h02;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic busy, done, opt_err, m_valid, m_ready;
    logic [7:0] tbl_idx, m_data;
    sorb_pkg::sorb_ent_s tbl [0:1];
    sorb_pkg::sorb_ent_s ent;
    logic [7:0] exp_b[$];
    int err_total = 0;
    int cmp_count = 0;

    // Table lookup is combinational, as the design expects
    assign ent = (tbl_idx < 8'h02) ? tbl[tbl_idx[0]] : '0;

    sorb_report u_sorb_report (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .req_valid_i(req_valid), .req_i(req), .busy_o(busy), .done_o(done),
        .opt_err_o(opt_err), .tbl_ready_i(tbl_ready), .tbl_count_i(tbl_count),
        .tbl_idx_o(tbl_idx), .tbl_ent_i(ent), .m_valid_o(m_valid),
        .m_ready_i(m_ready), .m_data_o(m_data));

    sorb_sink u_sorb_sink (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .valid_i(m_valid),
        .data_i(m_data), .hold_i(hold), .slow_i(slow), .ready_o(m_ready));

    // 25 MHz clock
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk1(input string what, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, e, g);
        end
    endtask

    // Multi-byte fields go out high byte first
    task automatic put32(input logic [31:0] v);
        for (int i = 3; i >= 0; i--) exp_b.push_back(v[i*8 +: 8]);
    endtask

    task automatic put_to(input int k);
        put32({8'h00, 8'h0A, 8'h00, tbl[k].cs_valid ? tbl[k].cs : 8'h00});
        put32(tbl[k].nom);
        put32(tbl[k].rec);
    endtask

    task automatic exp_all(input logic return_timeout_desc_request);
        exp_b.delete();
        put32(return_timeout_desc_request ? 32'h0000_0028 : 32'h0000_0010);
        for (int k = 0; k < 2; k++) begin
            put32({tbl[k].op, 8'h00, tbl[k].sa_valid ? tbl[k].sa : 16'h0000});
            put32({8'h00, 6'h00, return_timeout_desc_request, tbl[k].sa_valid, 8'h00, 3'h0, tbl[k].cdb_len});
            if (return_timeout_desc_request) put_to(k);
        end
    endtask

    task automatic exp_one(input int k, input sorb_pkg::sorb_sup_e sup, input logic return_timeout_desc_request);
        exp_b.delete();
        if (sup == sorb_pkg::SUP_NA || sup == sorb_pkg::SUP_NO) begin
            put32({8'h00, 5'h00, sup, 16'h0000});
        end else begin
            put32({8'h00, return_timeout_desc_request, 4'h0, sup, 11'h000, tbl[k].cdb_len});
            for (int i = 0; i < tbl[k].cdb_len; i++) begin
                if (i == 0) exp_b.push_back(tbl[k].op);
                else if (tbl[k].sa_valid && i == tbl[k].sa_pos)
                    exp_b.push_back({tbl[k].usage[i][7:5], tbl[k].sa[4:0]});
                else exp_b.push_back(tbl[k].usage[i]);
            end
            if (return_timeout_desc_request) put_to(k);
        end
    endtask

    // One-cycle request strobe, raised and dropped at falling edges
    task automatic start(input logic [2:0] opt, input logic return_timeout_desc_request, input logic [7:0] op,
                         input logic [15:0] sa, input logic [31:0] alloc);
        @(negedge clk_sys_i);
        u_sorb_sink.got.delete();
        req = '{opt: opt, return_timeout_desc_request: return_timeout_desc_request, op: op, sa: sa, alloc: alloc};
        req_valid = 1'b1;
        @(negedge clk_sys_i);
        req_valid = 1'b0;
    endtask

    // Bounded waits for done and for the buffer to drain, then compare stream
    task automatic finish();
        int n;
        for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge clk_sys_i);
        chk1("done", 1'b1, done);
        for (n = 0; n < 3000 && m_valid !== 1'b0; n++) @(negedge clk_sys_i);
        chk8("count", 8'(exp_b.size()), 8'(u_sorb_sink.got.size()));
        for (int i = 0; i < exp_b.size() && i < u_sorb_sink.got.size(); i++)
            chk8("byte", exp_b[i], u_sorb_sink.got[i]);
    endtask

    task automatic run(input logic [2:0] opt, input logic return_timeout_desc_request, input logic [7:0] op,
                       input logic [15:0] sa, input logic [31:0] alloc);
        start(opt, return_timeout_desc_request, op, sa, alloc);
        finish();
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #2000000;
        err_total++;
        report_and_stop();
    end

    initial begin
        tbl[0] = '{op: 8'h12, sa: 16'h0000, sa_valid: 1'b0, vendor: 1'b0, cs_valid: 1'b0,
            cs: 8'h5A, cdb_len: 5'h06, sa_pos: 4'h0,
            usage: {8'h12, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'h07, 80'h0},
            nom: 32'h0102_0304, rec: 32'hA1B2_C3D4};
        tbl[1] = '{op: 8'h9E, sa: 16'h0010, sa_valid: 1'b1, vendor: 1'b1, cs_valid: 1'b1,
            cs: 8'h07, cdb_len: 5'h10, sa_pos: 4'h1,
            usage: {8'h9E, 8'hE0, 8'hFF, 8'h0F, 96'hFFFF_0000_FFFF_0000_FFFF_00C3},
            nom: 32'h1122_3344, rec: 32'h5566_7788};
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        resetn_i = 1'b1;
        exp_all(1'b0);
        run(sorb_pkg::OPT_ALL, 1'b0, 8'hFF, 16'hFFFF, 32'h100);
        slow = 1'b1;
        exp_all(1'b1);
        run(sorb_pkg::OPT_ALL, 1'b1, 8'h00, 16'h0000, 32'h100);
        slow = 1'b0;
        exp_all(1'b1);
        while (exp_b.size() > 10) exp_b.pop_back();
        run(sorb_pkg::OPT_ALL, 1'b1, 8'h00, 16'h0000, 32'h00A);
        exp_one(0, sorb_pkg::SUP_STD, 1'b1);
        run(sorb_pkg::OPT_OP, 1'b1, 8'h12, 16'h0000, 32'h100);
        exp_one(1, sorb_pkg::SUP_VEN, 1'b0);
        run(sorb_pkg::OPT_OPSA, 1'b0, 8'h9E, 16'h0010, 32'h100);
        exp_one(1, sorb_pkg::SUP_NO, 1'b1);
        run(sorb_pkg::OPT_OP, 1'b1, 8'h9E, 16'h0010, 32'h100);
        exp_one(0, sorb_pkg::SUP_STD, 1'b0);
        run(sorb_pkg::OPT_CHK, 1'b0, 8'h12, 16'h0000, 32'h100);
        exp_one(0, sorb_pkg::SUP_NO, 1'b0);
        run(sorb_pkg::OPT_CHK, 1'b0, 8'h12, 16'h0005, 32'h100);
        tbl_ready = 1'b0;
        exp_one(0, sorb_pkg::SUP_NA, 1'b1);
        run(sorb_pkg::OPT_OP, 1'b1, 8'h12, 16'h0000, 32'h100);
        tbl_ready = 1'b1;
        exp_b.delete();
        run(3'h5, 1'b0, 8'h12, 16'h0000, 32'h100);
        chk1("opt_err", 1'b1, opt_err);
        exp_b.delete();
        run(sorb_pkg::OPT_ALL, 1'b0, 8'h00, 16'h0000, 32'h000);
        chk1("opt_err", 1'b0, opt_err);
        // Empty table: bare header, and a single request finds nothing
        tbl_count = 8'h00;
        exp_b.delete();
        put32(32'h0000_0000);
        run(sorb_pkg::OPT_ALL, 1'b1, 8'h00, 16'h0000, 32'h100);
        exp_one(0, sorb_pkg::SUP_NO, 1'b1);
        run(sorb_pkg::OPT_OP, 1'b1, 8'h12, 16'h0000, 32'h100);
        tbl_count = 8'h02;
        // Stalled reader fills the buffer; a request while busy must be ignored
        hold = 1'b1;
        exp_all(1'b1);
        start(sorb_pkg::OPT_ALL, 1'b1, 8'h00, 16'h0000, 32'h100);
        repeat (30) @(negedge clk_sys_i);
        chk1("busy", 1'b1, busy);
        start(3'h5, 1'b0, 8'h00, 16'h0000, 32'h100);
        hold = 1'b0;
        finish();
        chk1("opt_err", 1'b0, opt_err);
        report_and_stop();
    end
endmodule
